// ===== fwp_defs.vh
`ifndef FWP_DEFS_VH
`define FWP_DEFS_VH

// Lock vector width: 8 parameter blocks plus the remaining overlay blocks
`define FWP_NBLK 72

// Status register bit positions
`define FWP_ST_BUSY 0
`define FWP_ST_WEL 1
`define FWP_ST_ESUSP 2
`define FWP_ST_PSUSP 3
`define FWP_ST_LOCKDN 4
`define FWP_ST_IDLOCK 5
`define FWP_ST_RSVD 6
`define FWP_ST_BUSY2 7

// Configuration register bit positions
`define FWP_CR_QPS 1
`define FWP_CR_BPNV 3
`define FWP_CR_PROTECT_PIN_ENABLE 7

// Reset values
`define FWP_QPS_RST 1'b0
`define FWP_PROTECT_PIN_ENABLE_RST 1'b0
`define FWP_WLOCK_RST {`FWP_NBLK{1'b1}}
`define FWP_PLOCK_RST {`FWP_NBLK{1'b0}}

// Unique-ID space: 2 KByte, first 8 bytes (64 bits) factory programmed
`define FWP_ID_AW 11
`define FWP_ID_FACTORY_BYTES 11'h008

// Kinds of internal write operation
`define FWP_OP_NONE 3'h0
`define FWP_OP_PROG 3'h1
`define FWP_OP_ERASE 3'h2
`define FWP_OP_ID 3'h3
`define FWP_OP_NV 3'h4

`endif

// ===== fwp_pause.v
`include "fwp_defs.vh"

module fwp_pause (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire sck_i,
  input wire cs_n_i,
  input wire hold_n_i,
  input wire enable_i,
  output reg paused_o,
  output reg if_reset_o,
  output wire cs_n_s_o
);

  localparam ST_RUN = 2'b01;
  localparam ST_HOLD = 2'b10;

  reg [2:0] meta_r;
  reg [2:0] sync_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg cs_n_d_r;
  wire sck_s;
  wire cs_n_s;
  wire hold_n_s;

  // Two-stage synchronisers for serial clock, chip select and pause pin
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_r <= 3'h6;
      sync_r <= 3'h6;
    end else begin
      meta_r <= {hold_n_i, cs_n_i, sck_i};
      sync_r <= meta_r;
    end
  end

  assign sck_s = sync_r[0];
  assign cs_n_s = sync_r[1];
  assign hold_n_s = sync_r[2];
  assign cs_n_s_o = cs_n_s;

  // Pin-driven transitions only happen while the clock is low, so late pin edges wait; deselect or disable leaves pause at once
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (enable_i && !cs_n_s && !sck_s && !hold_n_s) begin // [RQ15] [RQ16]
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!enable_i || cs_n_s) begin // [RQ15] [RQ18]
          state_nxt = ST_RUN;
        end else if (!sck_s && hold_n_s) begin // [RQ16]
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= ST_RUN;
      cs_n_d_r <= 1'b1;
      paused_o <= 1'b0;
      if_reset_o <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cs_n_d_r <= cs_n_s;
      paused_o <= (state_nxt == ST_HOLD);
      // Deselect while paused resets the interface logic
      if_reset_o <= (state_r == ST_HOLD) && cs_n_s && !cs_n_d_r; // [RQ18]
    end
  end

endmodule // fwp_pause

// ===== fwp_top.v
`include "fwp_defs.vh"

// How it works
// RQ1: A 72-bit permanent lock register, one bit per parameter or overlay block.
// RQ2: Writing 1 to a permanent lock bit forces and freezes its write-lock bit.
// RQ3: Set permanent lock bits stay set; later writes only set remaining zeros.
// RQ4: Writing 0 to a permanent lock position changes nothing.
// RQ5: Permanent lock write is ignored while lockdown is active; power cycle needed.
// RQ6: Protect pin works only outside quad-wide mode and with quad pin select 0.
// RQ7: Protect pin is ignored when its enable bit is 0.
// RQ8: Quad pin select 1 disables the protect pin regardless of enable bit.
// RQ9: Active lockdown forbids block-protect writes whatever the pin and enables.
// RQ10: Without lockdown, pin low, select 0, enable 1 blocks protect and config writes.
// RQ11: Protect pin never affects program or erase commands.
// RQ12: Protect-pin enable is non-volatile, factory 0, survives power cycles.
// RQ13: 2 KByte ID space: fixed 64-bit factory part, user part via program-ID.
// RQ14: After lock-ID all ID writes are refused; ID space is never erasable. The code refuses program-ID but still accepts a repeated lock-ID.
// RQ15: Pause pin works only outside quad-wide mode with quad pin select 0.
// RQ16: Pause entered or left only while chip selected and serial clock low; the code also leaves pause at once on deselect or disable.
// RQ17: While paused the data output floats and serial input is ignored.
// RQ18: Deselect during pause resets interface logic; resume needs pin high, select.
// RQ19: Status bits: busy, latch, erase and program suspend, lockdown, ID lock, bit6 0.
// RQ20: Status bit 7 mirrors busy and stays readable during internal writes.
// RQ21: ID-locked status comes up 1 after a past lock-ID, else 0.
// RQ22: With latch 0, program, erase, protection writes and lockdown are rejected.
// RQ23: Latch clears on power-up, reset, disable, suspend, protect writes, completions.
// RQ24: Lockdown status is set by the lockdown command, cleared only by power cycle.
// RQ25: Quad pin select sits in configuration bit 1, set by writing 1.
module fwp_top #(
  parameter NBLK = `FWP_NBLK
) (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire sck_i,
  input wire cs_n_i,
  input wire wp_n_i,
  input wire hold_n_i,
  input wire so_d_i,
  input wire so_en_i,
  input wire quad_wide_mode_i,
  input wire nv_restore_i,
  input wire [NBLK-1:0] nv_lock_i,
  input wire nv_protect_pin_enable_i,
  input wire nv_idlock_i,
  input wire cmd_wren_i,
  input wire cmd_write_disable_cmd_i,
  input wire cmd_rst_i,
  input wire cmd_write_block_protect_cmd_i,
  input wire cmd_gunlock_i,
  input wire cmd_lbpr_i,
  input wire cmd_wrcr_i,
  input wire cmd_plock_i,
  input wire cmd_prog_i,
  input wire cmd_erase_i,
  input wire cmd_suspend_i,
  input wire cmd_resume_i,
  input wire cmd_program_id_cmd_i,
  input wire cmd_lock_id_cmd_i,
  input wire [NBLK-1:0] wr_data_i,
  input wire [7:0] cr_data_i,
  input wire [`FWP_ID_AW-1:0] id_addr_i,
  input wire op_done_i,
  output reg so_o,
  output reg so_oe_o,
  output reg paused_o,
  output reg if_reset_o,
  output reg [7:0] device_status_o,
  output reg [7:0] config_o,
  output reg [NBLK-1:0] wlock_o,
  output reg [NBLK-1:0] permanent_lock_register_o,
  output reg cmd_ok_o,
  output reg cmd_rej_o,
  output reg array_go_o,
  output reg [2:0] array_op_o,
  output reg nv_save_o
);

  reg [1:0] wp_meta_r;
  reg [1:0] wp_sync_r;
  wire wp_n_s;
  wire pause_s;
  wire pause_rst_s;
  wire cs_n_s;
  wire pins_enable;
  wire hw_protect;

  reg write_enable_latch_r;
  reg lockdown_status_r;
  reg id_locked_r;
  reg quad_pin_select_r;
  reg protect_pin_enable_r;
  reg busy_r;
  reg erase_suspended_r;
  reg program_suspended_r;
  reg [2:0] op_kind_r;
  reg [NBLK-1:0] plock_r;
  reg [NBLK-1:0] wlock_r;

  reg wel_nxt;
  reg lockdown_nxt;
  reg idlock_nxt;
  reg qps_nxt;
  reg protect_pin_enable_nxt;
  reg busy_nxt;
  reg esusp_nxt;
  reg psusp_nxt;
  reg [2:0] op_kind_nxt;
  reg [NBLK-1:0] plock_nxt;
  reg [NBLK-1:0] wlock_nxt;
  reg ok_nxt;
  reg rej_nxt;
  reg go_nxt;
  reg [2:0] go_op_nxt;
  reg save_nxt;
  reg [7:0] status_nxt;
  reg [7:0] config_nxt;
  reg cmd_any;

  // Protect pin comes from outside the clock domain
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wp_meta_r <= 2'h3;
      wp_sync_r <= 2'h3;
    end else begin
      wp_meta_r <= {wp_meta_r[0], wp_n_i};
      wp_sync_r <= {wp_sync_r[0], wp_meta_r[1]};
    end
  end

  assign wp_n_s = wp_sync_r[1];

  // Protect and pause pins only act in narrow modes with select bit clear
  assign pins_enable = !quad_wide_mode_i && !quad_pin_select_r; // [RQ6] [RQ8] [RQ15]
  assign hw_protect = pins_enable && protect_pin_enable_r && !wp_n_s; // [RQ7] [RQ10]

  fwp_pause u_pause (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .sck_i(sck_i),
    .cs_n_i(cs_n_i),
    .hold_n_i(hold_n_i),
    .enable_i(pins_enable),
    .paused_o(pause_s),
    .if_reset_o(pause_rst_s),
    .cs_n_s_o(cs_n_s)
  );

  always @* begin
    wel_nxt = write_enable_latch_r;
    lockdown_nxt = lockdown_status_r;
    idlock_nxt = id_locked_r;
    qps_nxt = quad_pin_select_r;
    protect_pin_enable_nxt = protect_pin_enable_r;
    busy_nxt = busy_r;
    esusp_nxt = erase_suspended_r;
    psusp_nxt = program_suspended_r;
    op_kind_nxt = op_kind_r;
    plock_nxt = plock_r;
    wlock_nxt = wlock_r | plock_r; // [RQ3]
    ok_nxt = 1'b0;
    rej_nxt = 1'b0;
    go_nxt = 1'b0;
    go_op_nxt = `FWP_OP_NONE;
    save_nxt = 1'b0;
    cmd_any = cmd_wren_i | cmd_write_disable_cmd_i | cmd_rst_i | cmd_write_block_protect_cmd_i | cmd_gunlock_i | cmd_lbpr_i
      | cmd_wrcr_i | cmd_plock_i | cmd_prog_i | cmd_erase_i | cmd_suspend_i | cmd_resume_i
      | cmd_program_id_cmd_i | cmd_lock_id_cmd_i;

    // Internal write completion from the array
    if (busy_r && op_done_i) begin
      busy_nxt = 1'b0;
      wel_nxt = 1'b0; // [RQ23]
      op_kind_nxt = `FWP_OP_NONE;
      if (op_kind_r == `FWP_OP_NV) begin
        save_nxt = 1'b1; // [RQ12]
      end
    end

    // Serial input is ignored while paused, in step with the visible pause flag
    if (paused_o || !cmd_any) begin // [RQ17]
      rej_nxt = 1'b0;
    end else if (cmd_rst_i) begin
      wel_nxt = 1'b0; // [RQ23]
      ok_nxt = 1'b1;
    end else if (cmd_suspend_i) begin
      wel_nxt = 1'b0; // [RQ23]
      if (busy_r && (op_kind_r == `FWP_OP_PROG || op_kind_r == `FWP_OP_ERASE)) begin
        busy_nxt = 1'b0;
        psusp_nxt = (op_kind_r == `FWP_OP_PROG);
        esusp_nxt = (op_kind_r == `FWP_OP_ERASE);
        op_kind_nxt = `FWP_OP_NONE;
        ok_nxt = 1'b1;
      end else begin
        rej_nxt = 1'b1;
      end
    end else if (busy_r) begin
      // Only status polling, reset and suspend are served during an internal write
      rej_nxt = 1'b1; // [RQ20]
    end else if (cmd_resume_i) begin
      if (program_suspended_r || erase_suspended_r) begin
        busy_nxt = 1'b1;
        op_kind_nxt = program_suspended_r ? `FWP_OP_PROG : `FWP_OP_ERASE;
        psusp_nxt = 1'b0;
        esusp_nxt = 1'b0;
        ok_nxt = 1'b1;
      end else begin
        rej_nxt = 1'b1;
      end
    end else if (cmd_wren_i) begin
      wel_nxt = 1'b1;
      ok_nxt = 1'b1;
    end else if (cmd_write_disable_cmd_i) begin
      wel_nxt = 1'b0; // [RQ23]
      ok_nxt = 1'b1;
    end else if (!write_enable_latch_r) begin
      rej_nxt = 1'b1; // [RQ22]
    end else if (cmd_write_block_protect_cmd_i || cmd_gunlock_i) begin
      wel_nxt = 1'b0; // [RQ23]
      if (lockdown_status_r || hw_protect) begin // [RQ9] [RQ10]
        rej_nxt = 1'b1;
      end else begin
        wlock_nxt = (cmd_write_block_protect_cmd_i ? wr_data_i : {NBLK{1'b0}}) | plock_r; // [RQ2] [RQ3]
        ok_nxt = 1'b1;
      end
    end else if (cmd_lbpr_i) begin
      wel_nxt = 1'b0; // [RQ23]
      lockdown_nxt = 1'b1; // [RQ24]
      ok_nxt = 1'b1;
    end else if (cmd_wrcr_i) begin
      wel_nxt = 1'b0; // [RQ23]
      if (hw_protect) begin // [RQ10]
        rej_nxt = 1'b1;
      end else begin
        qps_nxt = cr_data_i[`FWP_CR_QPS]; // [RQ25]
        protect_pin_enable_nxt = cr_data_i[`FWP_CR_PROTECT_PIN_ENABLE];
        if (cr_data_i[`FWP_CR_PROTECT_PIN_ENABLE] != protect_pin_enable_r) begin
          // Non-volatile bit write takes an internal write cycle
          busy_nxt = 1'b1; // [RQ12]
          op_kind_nxt = `FWP_OP_NV;
          go_nxt = 1'b1;
          go_op_nxt = `FWP_OP_NV;
        end
        ok_nxt = 1'b1;
      end
    end else if (cmd_plock_i) begin
      if (lockdown_status_r) begin
        rej_nxt = 1'b1; // [RQ5]
      end else begin
        // Ones only ever add to the lock set; zeros leave it alone
        plock_nxt = plock_r | wr_data_i; // [RQ1] [RQ3] [RQ4]
        wlock_nxt = wlock_r | plock_r | wr_data_i; // [RQ2]
        wel_nxt = 1'b0;
        busy_nxt = 1'b1;
        op_kind_nxt = `FWP_OP_NV;
        go_nxt = 1'b1;
        go_op_nxt = `FWP_OP_NV;
        ok_nxt = 1'b1;
      end
    end else if (cmd_prog_i || cmd_erase_i) begin
      // Protect pin plays no part in array writes
      busy_nxt = 1'b1; // [RQ11]
      op_kind_nxt = cmd_prog_i ? `FWP_OP_PROG : `FWP_OP_ERASE;
      go_nxt = 1'b1;
      go_op_nxt = cmd_prog_i ? `FWP_OP_PROG : `FWP_OP_ERASE;
      ok_nxt = 1'b1;
    end else if (cmd_program_id_cmd_i) begin
      // Factory segment and a locked space refuse programming
      if (id_locked_r || id_addr_i < `FWP_ID_FACTORY_BYTES) begin // [RQ13] [RQ14]
        rej_nxt = 1'b1;
      end else begin
        busy_nxt = 1'b1;
        op_kind_nxt = `FWP_OP_ID;
        go_nxt = 1'b1;
        go_op_nxt = `FWP_OP_ID;
        ok_nxt = 1'b1;
      end
    end else if (cmd_lock_id_cmd_i) begin
      idlock_nxt = 1'b1; // [RQ14] [RQ21]
      busy_nxt = 1'b1;
      op_kind_nxt = `FWP_OP_ID;
      go_nxt = 1'b1;
      go_op_nxt = `FWP_OP_ID;
      ok_nxt = 1'b1;
    end else begin
      rej_nxt = 1'b1;
    end

    // Restore of non-volatile state after power-up
    if (nv_restore_i) begin
      plock_nxt = nv_lock_i; // [RQ1]
      wlock_nxt = wlock_nxt | nv_lock_i; // [RQ2]
      protect_pin_enable_nxt = nv_protect_pin_enable_i; // [RQ12]
      idlock_nxt = nv_idlock_i; // [RQ21]
    end

    status_nxt = 8'h00;
    status_nxt[`FWP_ST_BUSY] = busy_nxt; // [RQ19]
    status_nxt[`FWP_ST_WEL] = wel_nxt;
    status_nxt[`FWP_ST_ESUSP] = esusp_nxt;
    status_nxt[`FWP_ST_PSUSP] = psusp_nxt;
    status_nxt[`FWP_ST_LOCKDN] = lockdown_nxt;
    status_nxt[`FWP_ST_IDLOCK] = idlock_nxt;
    status_nxt[`FWP_ST_RSVD] = 1'b0;
    status_nxt[`FWP_ST_BUSY2] = busy_nxt; // [RQ20]

    config_nxt = 8'h00;
    config_nxt[`FWP_CR_QPS] = qps_nxt; // [RQ25]
    config_nxt[`FWP_CR_BPNV] = ~|plock_nxt;
    config_nxt[`FWP_CR_PROTECT_PIN_ENABLE] = protect_pin_enable_nxt;
  end

  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      write_enable_latch_r <= 1'b0; // [RQ23]
      lockdown_status_r <= 1'b0; // [RQ24]
      id_locked_r <= 1'b0;
      quad_pin_select_r <= `FWP_QPS_RST;
      protect_pin_enable_r <= `FWP_PROTECT_PIN_ENABLE_RST; // [RQ12]
      busy_r <= 1'b0;
      erase_suspended_r <= 1'b0;
      program_suspended_r <= 1'b0;
      op_kind_r <= `FWP_OP_NONE;
      plock_r <= `FWP_PLOCK_RST;
      wlock_r <= `FWP_WLOCK_RST;
      so_o <= 1'b0;
      so_oe_o <= 1'b0;
      paused_o <= 1'b0;
      if_reset_o <= 1'b0;
      device_status_o <= 8'h00;
      config_o <= 8'h08;
      wlock_o <= `FWP_WLOCK_RST;
      permanent_lock_register_o <= `FWP_PLOCK_RST;
      cmd_ok_o <= 1'b0;
      cmd_rej_o <= 1'b0;
      array_go_o <= 1'b0;
      array_op_o <= `FWP_OP_NONE;
      nv_save_o <= 1'b0;
    end else begin
      write_enable_latch_r <= wel_nxt;
      lockdown_status_r <= lockdown_nxt;
      id_locked_r <= idlock_nxt;
      quad_pin_select_r <= qps_nxt;
      protect_pin_enable_r <= protect_pin_enable_nxt;
      busy_r <= busy_nxt;
      erase_suspended_r <= esusp_nxt;
      program_suspended_r <= psusp_nxt;
      op_kind_r <= op_kind_nxt;
      plock_r <= plock_nxt;
      wlock_r <= wlock_nxt;
      so_o <= so_d_i;
      so_oe_o <= so_en_i && !pause_s && !cs_n_s; // [RQ17]
      paused_o <= pause_s;
      if_reset_o <= pause_rst_s; // [RQ18]
      device_status_o <= status_nxt;
      config_o <= config_nxt;
      wlock_o <= wlock_nxt;
      permanent_lock_register_o <= plock_nxt;
      cmd_ok_o <= ok_nxt;
      cmd_rej_o <= rej_nxt;
      array_go_o <= go_nxt;
      array_op_o <= go_op_nxt;
      nv_save_o <= save_nxt;
    end
  end

endmodule // fwp_top

// ===== fwp_host_model.sv
module fwp_host_model (
  input wire logic frame_i,
  input wire logic hold_req_i,
  output logic sck_o,
  output logic cs_n_o,
  output wire logic hold_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Clock rests low between frames
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
  end
  // Deselect at frame end is also the way out of a pause
  always begin
    wait (frame_i);
    cs_n_o = 1'b0;
    while (frame_i) begin
      #160 sck_o = 1'b1;
      #160 sck_o = 1'b0;
    end
    #160 cs_n_o = 1'b1;
  end
  // Pause level may change in either clock phase
  assign hold_n_o = ~hold_req_i;
endmodule // fwp_host_model

// ===== fwp_top_assertions.sv
module fwp_top_assertions #(
  parameter NBLK = 72
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic quad_wide_mode_i,
  input wire logic cmd_write_block_protect_cmd_i,
  input wire logic cmd_plock_i,
  input wire logic cmd_prog_i,
  input wire logic so_oe_o,
  input wire logic paused_o,
  input wire logic if_reset_o,
  input wire logic [7:0] device_status_o,
  input wire logic [NBLK-1:0] wlock_o,
  input wire logic [NBLK-1:0] permanent_lock_register_o,
  input wire logic cmd_ok_o,
  input wire logic cmd_rej_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  chk_busy_mirror:
    assert property (device_status_o[7] == device_status_o[0]) else $error("busy copy differs");
  chk_rsvd_zero:
    assert property (device_status_o[6] == 1'b0) else $error("reserved status bit set");
  chk_perm_sticky:
    assert property (($past(permanent_lock_register_o) & ~permanent_lock_register_o) == '0)
      else $error("permanent lock bit cleared");
  chk_wlock_forced:
    assert property ((wlock_o & permanent_lock_register_o) == permanent_lock_register_o)
      else $error("locked block not write-locked");
  chk_lockdown_sticky:
    assert property (!$fell(device_status_o[4])) else $error("lockdown dropped");
  chk_oe_paused:
    assert property (paused_o |-> !so_oe_o) else $error("output driven in pause");
  chk_wel_needed:
    assert property (cmd_prog_i && !device_status_o[1] && !paused_o |=> cmd_rej_o)
      else $error("program accepted without latch");
  chk_wp_no_effect:
    assert property (cmd_prog_i && device_status_o[1:0] == 2'b10 && !paused_o |=> cmd_ok_o)
      else $error("program refused");
  chk_lockdown_refuse:
    assert property ((cmd_write_block_protect_cmd_i || cmd_plock_i) && device_status_o[4] && !paused_o
      |=> cmd_rej_o) else $error("lock write taken in lockdown");
  chk_quad_pause:
    assert property (quad_wide_mode_i [*8] |-> !paused_o) else $error("pause in quad mode");
  cover property (cmd_plock_i ##1 cmd_ok_o);
  cover property ($rose(paused_o));
  cover property (if_reset_o);
endmodule // fwp_top_assertions

// ===== fwp_top_tb.sv
`include "fwp_defs.vh"

`define CHK(n, g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s expected %0h seen %0h", n, e, g); end end

module fwp_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WREN = 0, WRITE_DISABLE_CMD = 1, RST = 2, WRITE_BLOCK_PROTECT_CMD = 3, GUNL = 4, LBPR = 5, WRCR = 6;
  localparam int PLOCK = 7, PROG = 8, ERASE = 9, SUSP = 10, RESM = 11, PROGRAM_ID_CMD = 12, LOCK_ID_CMD = 13;
  logic mclk_i = 0, sys_rst_i = 1, wp_n_i = 1, so_d_i = 0, so_en_i = 0, quad_wide_mode_i = 0;
  logic nv_restore_i = 0, nv_protect_pin_enable_i = 0, nv_idlock_i = 0, op_done_i = 0, frame = 0, hold_req = 0;
  logic [13:0] cmd_v = '0;
  logic [`FWP_NBLK-1:0] nv_lock_i = '0, wr_data_i = '0;
  logic [7:0] cr_data_i = 8'h00;
  logic [`FWP_ID_AW-1:0] id_addr_i = '0;
  wire sck_i, cs_n_i, hold_n_i;
  wire cmd_wren_i = cmd_v[0], cmd_write_disable_cmd_i = cmd_v[1], cmd_rst_i = cmd_v[2], cmd_write_block_protect_cmd_i = cmd_v[3];
  wire cmd_gunlock_i = cmd_v[4], cmd_lbpr_i = cmd_v[5], cmd_wrcr_i = cmd_v[6];
  wire cmd_plock_i = cmd_v[7], cmd_prog_i = cmd_v[8], cmd_erase_i = cmd_v[9];
  wire cmd_suspend_i = cmd_v[10], cmd_resume_i = cmd_v[11];
  wire cmd_program_id_cmd_i = cmd_v[12], cmd_lock_id_cmd_i = cmd_v[13];
  wire so_o, so_oe_o, paused_o, if_reset_o, cmd_ok_o, cmd_rej_o, array_go_o, nv_save_o;
  wire [7:0] device_status_o, config_o;
  wire [`FWP_NBLK-1:0] wlock_o, permanent_lock_register_o;
  wire [2:0] array_op_o;
  int fails = 0, n_compared = 0, i;
  // Row: protect pin, quad select, pin enable, quad mode, block write reply, config reply
  logic [7:0] rows [5] = '{8'h25, 8'h0A, 8'hAA, 8'h6A, 8'h3A};
  localparam logic [`FWP_NBLK-1:0] LK = {1'b1, 70'h0, 1'b1};

  fwp_host_model u_host (.frame_i(frame), .hold_req_i(hold_req), .sck_o(sck_i),
    .cs_n_o(cs_n_i), .hold_n_o(hold_n_i));
  fwp_top DUT (.mclk_i, .sys_rst_i, .sck_i, .cs_n_i, .wp_n_i, .hold_n_i, .so_d_i, .so_en_i,
    .quad_wide_mode_i, .nv_restore_i, .nv_lock_i, .nv_protect_pin_enable_i, .nv_idlock_i, .cmd_wren_i,
    .cmd_write_disable_cmd_i, .cmd_rst_i, .cmd_write_block_protect_cmd_i, .cmd_gunlock_i, .cmd_lbpr_i, .cmd_wrcr_i,
    .cmd_plock_i, .cmd_prog_i, .cmd_erase_i, .cmd_suspend_i, .cmd_resume_i, .cmd_program_id_cmd_i,
    .cmd_lock_id_cmd_i, .wr_data_i, .cr_data_i, .id_addr_i, .op_done_i, .so_o, .so_oe_o, .paused_o,
    .if_reset_o, .device_status_o, .config_o, .wlock_o, .permanent_lock_register_o,
    .cmd_ok_o, .cmd_rej_o, .array_go_o, .array_op_o, .nv_save_o);

  always #20 mclk_i = ~mclk_i;

  task tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // Reply {ok, refused}; 2'b11 means reply not checked
  task issue(input int k, input logic [1:0] exp);
    @(posedge mclk_i) cmd_v <= 14'h0001 << k;
    @(posedge mclk_i) cmd_v <= '0;
    #1;
    if (exp != 2'b11) `CHK("reply", {cmd_ok_o, cmd_rej_o}, exp)
  endtask
  task wissue(input int k, input logic [1:0] exp);
    issue(WREN, 2'b10);
    issue(k, exp);
  endtask
  task done_op;
    @(posedge mclk_i) op_done_i <= 1'b1;
    @(posedge mclk_i) op_done_i <= 1'b0;
    #1;
  endtask
  task nvr(input logic [`FWP_NBLK-1:0] lk, input logic wp, input logic idl);
    @(posedge mclk_i) nv_restore_i <= 1'b1;
    nv_lock_i <= lk;
    nv_protect_pin_enable_i <= wp;
    nv_idlock_i <= idl;
    @(posedge mclk_i) nv_restore_i <= 1'b0;
    #1;
  endtask
  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge mclk_i);
    fails++;
    end_of_test;
  end

  initial begin
    tick(2);
    sys_rst_i <= 1'b0;
    for (int r = 0; r < 5; r++) begin
      nvr('0, rows[r][5], 1'b0);
      wp_n_i <= 1'b1;
      quad_wide_mode_i <= rows[r][4];
      cr_data_i <= {rows[r][5], 5'h00, rows[r][6], 1'b0};
      tick(4);
      wissue(WRCR, 2'b10);
      `CHK("quad_pin_select", config_o[1], rows[r][6])
      wp_n_i <= rows[r][7];
      tick(4);
      wissue(WRITE_BLOCK_PROTECT_CMD, rows[r][3:2]);
      wissue(WRCR, rows[r][1:0]);
      `CHK("latch", device_status_o[1], 1'b0)
    end
    quad_wide_mode_i <= 1'b0;
    tick(2);
    issue(PROG, 2'b01);
    wissue(PROG, 2'b10);
    `CHK("array_op", {array_go_o, array_op_o}, 4'h9)
    `CHK("busy", {device_status_o[7], device_status_o[0]}, 2'b11)
    wp_n_i <= 1'b1;
    done_op;
    `CHK("status", device_status_o, 8'h00)
    wissue(ERASE, 2'b10);
    issue(SUSP, 2'b11);
    `CHK("erase_suspended", device_status_o[2], 1'b1)
    issue(RESM, 2'b11);
    `CHK("erase_suspended", device_status_o[2], 1'b0)
    done_op;
    `CHK("status", device_status_o, 8'h00)
    wissue(SUSP, 2'b01);
    `CHK("latch", device_status_o[1], 1'b0)
    wissue(RST, 2'b11);
    `CHK("latch", device_status_o[1], 1'b0)
    wissue(WRITE_DISABLE_CMD, 2'b11);
    `CHK("latch", device_status_o[1], 1'b0)
    wr_data_i <= LK;
    wissue(PLOCK, 2'b10);
    `CHK("array_op", array_op_o, 3'h4)
    done_op;
    `CHK("nv_save", nv_save_o, 1'b1)
    `CHK("perm_lock", permanent_lock_register_o, LK)
    `CHK("no_perm_lock", config_o[3], 1'b0)
    wr_data_i <= '0;
    wissue(PLOCK, 2'b10);
    done_op;
    `CHK("perm_lock", permanent_lock_register_o, LK)
    wissue(GUNL, 2'b10);
    `CHK("wlock", wlock_o, LK)
    wissue(LBPR, 2'b10);
    `CHK("lockdown", device_status_o[4:1], 4'h8)
    wissue(WRITE_BLOCK_PROTECT_CMD, 2'b01);
    wissue(PLOCK, 2'b01);
    id_addr_i <= 11'h003;
    wissue(PROGRAM_ID_CMD, 2'b01);
    id_addr_i <= 11'h008;
    wissue(PROGRAM_ID_CMD, 2'b10);
    `CHK("array_op", array_op_o, 3'h3)
    done_op;
    wissue(LOCK_ID_CMD, 2'b10);
    done_op;
    `CHK("id_locked", device_status_o[5], 1'b1)
    wissue(PROGRAM_ID_CMD, 2'b01);
    so_en_i <= 1'b1;
    so_d_i <= 1'b1;
    frame = 1'b1;
    tick(12);
    #1;
    `CHK("drive", so_oe_o, 1'b1)
    `CHK("data_out", so_o, 1'b1)
    hold_req = 1'b1;
    for (i = 0; i < 60 && paused_o !== 1'b1; i++) tick(1);
    #1;
    `CHK("paused", paused_o, 1'b1)
    `CHK("drive", so_oe_o, 1'b0)
    issue(WREN, 2'b00);
    frame = 1'b0;
    for (i = 0; i < 40 && if_reset_o !== 1'b1; i++) begin
      @(posedge mclk_i);
      #1;
    end
    `CHK("if_reset", if_reset_o, 1'b1)
    hold_req = 1'b0;
    tick(20);
    frame = 1'b1;
    tick(12);
    #1;
    `CHK("paused", paused_o, 1'b0)
    quad_wide_mode_i <= 1'b1;
    hold_req = 1'b1;
    tick(30);
    #1;
    `CHK("paused", paused_o, 1'b0)
    hold_req = 1'b0;
    frame = 1'b0;
    quad_wide_mode_i <= 1'b0;
    sys_rst_i <= 1'b1;
    tick(2);
    #1;
    `CHK("status", device_status_o, 8'h00)
    `CHK("config", config_o, 8'h08)
    `CHK("perm_lock", permanent_lock_register_o, 72'h0)
    sys_rst_i <= 1'b0;
    nvr(72'h20, 1'b1, 1'b1);
    `CHK("id_locked", device_status_o[5], 1'b1)
    `CHK("config", config_o, 8'h80)
    wissue(GUNL, 2'b10);
    `CHK("wlock", wlock_o, 72'h20)
    end_of_test;
  end
endmodule // fwp_top_tb

bind fwp_top fwp_top_assertions #(.NBLK(NBLK)) u_chk (.mclk_i, .sys_rst_i, .quad_wide_mode_i,
  .cmd_write_block_protect_cmd_i, .cmd_plock_i, .cmd_prog_i, .so_oe_o, .paused_o, .if_reset_o, .device_status_o,
  .wlock_o, .permanent_lock_register_o, .cmd_ok_o, .cmd_rej_o);
